// ### common/asq_cfg.svh
// Register map, field positions and timing counts of the converter sequencer
// Summary of operation
// - Control bits 3..0 pick the channel; codes 0000..0111 mean inputs 0..7.
// - Control bit 4 at one disables the analog inputs, zero enables them.
// - Control bit 5 picks short (0) or long (1) conversion time.
// - Short conversion lasts 46 machine cycles from start to result load.
// - Writing one to control bit 6 starts a conversion; zero does nothing.
// - Done flag, control bit 7, goes to one when the result is loaded.
// - Start during a conversion restarts it from the first step.
// - The input is sampled during the first 4 machine cycles.
// - Reading the result register clears the done flag.
// - Result read during a conversion gives an invalid value.
// - Stop mode during conversion aborts it; done stays zero.
// - Stop mode after completion keeps the result register contents.
// - Reset clears all eight control and status bits.
// - Each conversion yields an unsigned 8-bit code.
// - State is read from the done flag, value from the result register.
`ifndef ASQ_CFG_SVH
`define ASQ_CFG_SVH
`define ASQ_OFS_CTRL 16'h000e
`define ASQ_OFS_RESULT 16'h000f
`define ASQ_OFS_IRQ_STAT 16'h0010
`define ASQ_OFS_IRQ_MASK 16'h0011
`define ASQ_BIT_DIS 4
`define ASQ_BIT_LONG 5
`define ASQ_BIT_GO 6
`define ASQ_BIT_DONE 7
`define ASQ_CTRL_RESET 8'h00
`define ASQ_IRQ_DONE 0
`define ASQ_IRQ_ABORT 1
// Four oscillator periods make one machine cycle
`define ASQ_MC_DIV_LAST 2'h3
`define ASQ_SAMPLE_MC 8'h04
`define ASQ_BIT_MC_SHORT 8'h05
`define ASQ_TAIL_MC_SHORT 8'h02
`define ASQ_BIT_MC_LONG 8'h16
`define ASQ_TAIL_MC_LONG 8'h04
`define ASQ_CONV_CLK_SHORT 16'h00b8
`define ASQ_CONV_CLK_LONG 16'h02e0
`define ASQ_SAMPLE_CLK 8'h10
`endif

// ### common/asq_pkg.sv
// Types shared by the converter sequencer modules
package asq_pkg;
   typedef enum logic [3:0] {
      ASQ_IDLE = 4'b0001,
      ASQ_SAMPLE = 4'b0010,
      ASQ_CONV = 4'b0100,
      ASQ_LOAD = 4'b1000
   } asq_state_t;
endpackage

// ### core/asq_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module asq_sync #(
   parameter int W = 2
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Asynchronous inputs and their clean copies
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } asq_sync_st_t;

   asq_sync_st_t s_q;
   asq_sync_st_t s_d;

   always_comb begin
      s_d = s_q;
      s_d.s1 = i_async;
      s_d.s2 = s_q.s1;
      s_d.s3 = s_q.s2;
      // Change taken only once second and third stage agree
      s_d.lvl = (s_q.s2 & s_q.s3) | (s_q.lvl & (s_q.s2 | s_q.s3));
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_sync = s_q.lvl;
endmodule

// ### core/asq_top.sv
// Converter sequencer: control register, SAR timing, stop abort, interrupt
`timescale 1ns/1ps
`include "asq_cfg.svh"
module asq_top (
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_NRST,
   // Register port
   input wire logic [15:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [7:0] O_RDATA,
   output logic O_IRQ,
   // Analog front end and power control
   input wire logic I_CMP,
   input wire logic I_STOP,
   output logic O_SAMPLE,
   output logic O_MUX_EN,
   output logic [2:0] O_MUX_SEL,
   output logic [7:0] O_DAC_CODE
);
   typedef struct packed {
      asq_pkg::asq_state_t st;
      logic [1:0] div;
      logic [7:0] cnt;
      logic [2:0] idx;
      logic [7:0] sar;
      logic [7:0] dac;
      logic [7:0] result;
      logic [3:0] chan;
      logic dis;
      logic long_t;
      logic lng;
      logic done;
      logic [1:0] ist;
      logic [1:0] imask;
      logic [7:0] rdata;
      logic irq;
      logic sample;
      logic mux_en;
      logic [2:0] mux_sel;
   } asq_top_st_t;

   asq_top_st_t s_q;
   asq_top_st_t s_d;
   logic [1:0] sync_w;
   logic cmp_s;
   logic stop_s;
   logic go;
   logic wr_ctrl;
   logic rd_res;

   // Comparator and stop request come from outside the clock domain
   asq_sync #(.W(2)) u_sync (
      .i_clk(I_CLK),
      .i_nrst(I_NRST),
      .i_async({I_STOP, I_CMP}),
      .o_sync(sync_w)
   );
   assign cmp_s = sync_w[0];
   assign stop_s = sync_w[1];

   assign wr_ctrl = I_WR && (I_ADDR == `ASQ_OFS_CTRL);
   assign go = wr_ctrl && I_WDATA[`ASQ_BIT_GO];
   assign rd_res = I_RD && (I_ADDR == `ASQ_OFS_RESULT);

   always_comb begin
      logic tick;
      logic done_set;
      logic abort_ev;
      logic [7:0] bit_mc;
      logic [7:0] tail_mc;
      logic [7:0] trial;
      tick = 1'b0;
      done_set = 1'b0;
      abort_ev = 1'b0;
      bit_mc = `ASQ_BIT_MC_SHORT;
      tail_mc = `ASQ_TAIL_MC_SHORT;
      trial = 8'h00;
      s_d = s_q;
      s_d.rdata = 8'h00;
      tick = (s_q.div == `ASQ_MC_DIV_LAST);
      s_d.div = s_q.div + 2'h1;
      if (s_q.lng) begin
         bit_mc = `ASQ_BIT_MC_LONG;
         tail_mc = `ASQ_TAIL_MC_LONG;
      end
      trial = s_q.sar | (8'h01 << s_q.idx);
      case (s_q.st)
         asq_pkg::ASQ_IDLE: begin
            s_d.cnt = 8'h00;
         end
         asq_pkg::ASQ_SAMPLE: begin
            if (tick) begin
               // Input held by sample stage for four machine cycles
               if (s_q.cnt == `ASQ_SAMPLE_MC - 8'h01) begin
                  s_d.st = asq_pkg::ASQ_CONV;
                  s_d.cnt = 8'h00;
                  s_d.idx = 3'h7;
                  s_d.sar = 8'h00;
               end else begin
                  s_d.cnt = s_q.cnt + 8'h01;
               end
            end
         end
         asq_pkg::ASQ_CONV: begin
            if (tick) begin
               if (s_q.cnt == bit_mc - 8'h01) begin
                  s_d.cnt = 8'h00;
                  // Comparator high: input above trial level, keep bit
                  if (cmp_s) begin
                     s_d.sar = trial;
                  end
                  if (s_q.idx == 3'h0) begin
                     s_d.st = asq_pkg::ASQ_LOAD;
                  end else begin
                     s_d.idx = s_q.idx - 3'h1;
                  end
               end else begin
                  s_d.cnt = s_q.cnt + 8'h01;
               end
            end
         end
         asq_pkg::ASQ_LOAD: begin
            if (tick) begin
               if (s_q.cnt == tail_mc - 8'h01) begin
                  s_d.result = s_q.sar;
                  done_set = 1'b1;
                  s_d.st = asq_pkg::ASQ_IDLE;
                  s_d.cnt = 8'h00;
               end else begin
                  s_d.cnt = s_q.cnt + 8'h01;
               end
            end
         end
         default: begin
            s_d.st = asq_pkg::ASQ_IDLE;
         end
      endcase
      if (stop_s) begin
         // Oscillator stop: converter halts, finished result untouched
         if (s_q.st != asq_pkg::ASQ_IDLE) begin
            s_d.st = asq_pkg::ASQ_IDLE;
            s_d.cnt = 8'h00;
            abort_ev = 1'b1;
            done_set = 1'b0;
            s_d.result = s_q.result;
         end
      end else if (go) begin
         // Restart from sampling, divider realigned for exact length
         s_d.st = asq_pkg::ASQ_SAMPLE;
         s_d.cnt = 8'h00;
         s_d.div = 2'h0;
         s_d.lng = I_WDATA[`ASQ_BIT_LONG];
      end
      if (wr_ctrl) begin
         s_d.chan = I_WDATA[3:0];
         s_d.dis = I_WDATA[`ASQ_BIT_DIS];
         s_d.long_t = I_WDATA[`ASQ_BIT_LONG];
      end
      // Completion wins over a clear in the same cycle
      s_d.done = done_set
         | (s_q.done & ~rd_res & ~(go & ~stop_s));
      if (stop_s && s_q.st != asq_pkg::ASQ_IDLE) begin
         s_d.done = 1'b0;
      end
      s_d.ist = s_q.ist;
      if (I_WR && I_ADDR == `ASQ_OFS_IRQ_STAT) begin
         s_d.ist = s_q.ist & ~I_WDATA[1:0];
      end
      s_d.ist[`ASQ_IRQ_DONE] = s_d.ist[`ASQ_IRQ_DONE] | done_set;
      s_d.ist[`ASQ_IRQ_ABORT] = s_d.ist[`ASQ_IRQ_ABORT] | abort_ev;
      if (I_WR && I_ADDR == `ASQ_OFS_IRQ_MASK) begin
         s_d.imask = I_WDATA[1:0];
      end
      if (I_RD) begin
         case (I_ADDR)
            `ASQ_OFS_CTRL: begin
               // Start bit is a strobe and reads as zero
               s_d.rdata = {s_q.done, 1'b0, s_q.long_t, s_q.dis,
                  s_q.chan};
            end
            `ASQ_OFS_RESULT: begin
               // Mid-conversion this is stale data, not a live code
               s_d.rdata = s_q.result;
            end
            `ASQ_OFS_IRQ_STAT: begin
               s_d.rdata = {6'h00, s_q.ist};
            end
            `ASQ_OFS_IRQ_MASK: begin
               s_d.rdata = {6'h00, s_q.imask};
            end
            default: begin
               s_d.rdata = 8'h00;
            end
         endcase
      end
      if (s_d.st == asq_pkg::ASQ_CONV) begin
         s_d.dac = s_d.sar | (8'h01 << s_d.idx);
      end else begin
         s_d.dac = s_d.sar;
      end
      s_d.sample = (s_d.st == asq_pkg::ASQ_SAMPLE);
      // Code 1xxx selects no input, so the mux is closed
      s_d.mux_en = ~s_d.dis & ~s_d.chan[3];
      s_d.mux_sel = s_d.chan[2:0];
      s_d.irq = |(s_d.ist & s_d.imask);
   end

   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         s_q <= '0;
         s_q.st <= asq_pkg::ASQ_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign O_RDATA = s_q.rdata;
   assign O_IRQ = s_q.irq;
   assign O_SAMPLE = s_q.sample;
   assign O_MUX_EN = s_q.mux_en;
   assign O_MUX_SEL = s_q.mux_sel;
   assign O_DAC_CODE = s_q.dac;

   // Helper counters read only by the checks below
   logic [15:0] conv_clk_q;
   logic [7:0] smp_clk_q;
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         conv_clk_q <= 16'h0000;
         smp_clk_q <= 8'h00;
      end else begin
         if (go) begin
            conv_clk_q <= 16'h0000;
         end else if (s_q.st != asq_pkg::ASQ_IDLE) begin
            conv_clk_q <= conv_clk_q + 16'h0001;
         end
         if (go || !s_q.sample) begin
            smp_clk_q <= 8'h00;
         end else begin
            smp_clk_q <= smp_clk_q + 8'h01;
         end
      end
   end

   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_NRST);

   short_time_a: assert property (
      ($rose(s_q.done) && !s_q.lng) |-> conv_clk_q == `ASQ_CONV_CLK_SHORT)
      else $error("short conversion length wrong");
   long_time_a: assert property (
      ($rose(s_q.done) && s_q.lng) |-> conv_clk_q == `ASQ_CONV_CLK_LONG)
      else $error("long conversion length wrong");
   sample_window_a: assert property (
      (s_q.st == asq_pkg::ASQ_CONV && $fell(O_SAMPLE))
      |-> smp_clk_q == `ASQ_SAMPLE_CLK)
      else $error("sample window not four machine cycles");
   go_reads_zero_a: assert property (
      (I_RD && I_ADDR == `ASQ_OFS_CTRL) |=> !O_RDATA[`ASQ_BIT_GO])
      else $error("start bit read back as one");
   ctrl_readback_a: assert property (
      (wr_ctrl ##1 (I_RD && I_ADDR == `ASQ_OFS_CTRL && !I_WR))
      |=> O_RDATA[5:0] == $past(I_WDATA[5:0], 2))
      else $error("control fields not stored");
   read_clears_a: assert property (
      (rd_res && s_q.st == asq_pkg::ASQ_IDLE) |=> !s_q.done)
      else $error("result read left done flag set");
   restart_a: assert property (
      (go && !stop_s) |=> (s_q.st == asq_pkg::ASQ_SAMPLE && s_q.cnt == 8'h00)
      ##1 O_SAMPLE)
      else $error("start did not restart sampling");
   stop_abort_a: assert property (
      (stop_s && s_q.st != asq_pkg::ASQ_IDLE)
      |=> (s_q.st == asq_pkg::ASQ_IDLE && !s_q.done) [*2])
      else $error("stop did not abort conversion");
   stop_hold_a: assert property (
      (stop_s && s_q.done) |=> $stable(s_q.result))
      else $error("result lost in stop mode");
   mux_gate_a: assert property (
      (wr_ctrl && I_WDATA[`ASQ_BIT_DIS]) |=> !O_MUX_EN)
      else $error("disabled inputs left mux open");
   irq_level_a: assert property (
      O_IRQ == |(s_q.ist & s_q.imask))
      else $error("interrupt level mismatch");

   short_done_c: cover property ($rose(s_q.done) && !s_q.lng);
   long_done_c: cover property ($rose(s_q.done) && s_q.lng);
   restart_c: cover property (go && s_q.st == asq_pkg::ASQ_CONV);
   stop_abort_c: cover property (stop_s && s_q.st == asq_pkg::ASQ_LOAD);
endmodule

// ### verif/adc_sequencer_control_tb_top.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`include "asq_cfg.svh"
module adc_sequencer_control_tb_top;
   localparam logic [63:0] LEVELS = 64'hff_c3_81_7e_5a_3c_01_00;
   logic clk, nrst, wr, rd, stop, cmp, irq, smp, mux_en;
   logic [15:0] addr;
   logic [7:0] wdata, rdata, dac;
   logic [2:0] sel;
   int n_mismatch = 0;
   int checks = 0;
   asq_top uut (.I_CLK(clk), .I_NRST(nrst), .I_ADDR(addr),
      .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_IRQ(irq),
      .I_CMP(cmp), .I_STOP(stop), .O_SAMPLE(smp), .O_MUX_EN(mux_en),
      .O_MUX_SEL(sel), .O_DAC_CODE(dac));
   asq_analog_src src (.i_clk(clk), .i_sample(smp), .i_mux_en(mux_en),
      .i_mux_sel(sel), .i_dac_code(dac), .i_levels(LEVELS), .o_cmp(cmp));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Extra edge at the end keeps two strobes from landing in one step
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
      @(posedge clk);
   endtask
   // Start, then check sampling window and exact completion moment
   task automatic conv(input logic [7:0] c, input int n);
      logic [7:0] v;
      int k;
      k = 0;
      wr_reg(`ASQ_OFS_CTRL, c | 8'h40);
      repeat (15) @(negedge clk) if (smp === 1'b1) k++;
      @(negedge clk);
      chk({6'h00, k == 15, smp}, 8'h02);
      chk({4'h0, mux_en, sel}, {4'h0, ~c[4] & ~c[3], c[2:0]});
      repeat (n - 17) @(posedge clk);
      rd_reg(`ASQ_OFS_CTRL, v);
      chk(v, c & 8'h3f);
      rd_reg(`ASQ_OFS_CTRL, v);
      chk(v, (c & 8'h3f) | 8'h80);
   endtask
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      #100000;
      n_mismatch++;
      summarize();
   end
   initial begin
      logic [7:0] v;
      nrst = 1'b0;
      addr = 16'h0000;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      stop = 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd_reg(`ASQ_OFS_CTRL, v);
      chk(v, `ASQ_CTRL_RESET);
      rd_reg(`ASQ_OFS_IRQ_STAT, v);
      chk(v, 8'h00);
      wr_reg(16'h0020, 8'hff);
      rd_reg(16'h0020, v);
      chk(v, 8'h00);
      wr_reg(`ASQ_OFS_IRQ_MASK, 8'h03);
      rd_reg(`ASQ_OFS_IRQ_MASK, v);
      chk(v, 8'h03);
      // Done bit is not writable and go written as zero starts nothing
      wr_reg(`ASQ_OFS_CTRL, 8'h93);
      rd_reg(`ASQ_OFS_CTRL, v);
      chk(v, 8'h13);
      chk({6'h00, smp, mux_en}, 8'h00);
      $display("test reset and register map done");
      for (int ch = 0; ch < 8; ch++) begin
         wr_reg(`ASQ_OFS_IRQ_MASK, {7'h00, ch[0]});
         conv(ch[7:0], 184);
         chk({7'h00, irq}, {7'h00, ch[0]});
         rd_reg(`ASQ_OFS_RESULT, v); // Done polled first
         chk(v, LEVELS[ch*8+:8]);
         rd_reg(`ASQ_OFS_CTRL, v);
         chk(v, ch[7:0]);
         wr_reg(`ASQ_OFS_IRQ_STAT, 8'h01);
         rd_reg(`ASQ_OFS_IRQ_STAT, v);
         chk({v[6:0], irq}, 8'h00);
      end
      $display("test channel sweep done");
      conv(8'h25, 736);
      rd_reg(`ASQ_OFS_RESULT, v);
      chk(v, LEVELS[47:40]);
      $display("test long conversion done");
      wr_reg(`ASQ_OFS_CTRL, 8'h42);
      repeat (100) @(posedge clk);
      conv(8'h42, 184);
      // Stop after completion keeps result and flag
      stop <= 1'b1;
      repeat (20) @(posedge clk);
      stop <= 1'b0;
      repeat (10) @(posedge clk);
      rd_reg(`ASQ_OFS_CTRL, v);
      chk(v, 8'h82);
      rd_reg(`ASQ_OFS_RESULT, v);
      chk(v, LEVELS[23:16]);
      $display("test restart and idle stop done");
      wr_reg(`ASQ_OFS_IRQ_STAT, 8'h03);
      wr_reg(`ASQ_OFS_CTRL, 8'h46);
      repeat (50) @(posedge clk);
      stop <= 1'b1;
      repeat (20) @(posedge clk);
      stop <= 1'b0;
      repeat (300) @(posedge clk);
      rd_reg(`ASQ_OFS_CTRL, v);
      chk(v, 8'h06);
      rd_reg(`ASQ_OFS_IRQ_STAT, v);
      chk(v, 8'h02);
      $display("test stop abort done");
      summarize();
   end
endmodule

// ### verif/asq_analog_src.sv
// Analog sources with sample-and-hold and comparator for the sequencer
`timescale 1ns/1ps
module asq_analog_src (
   // Clock
   input wire logic i_clk,
   // Front-end controls from the sequencer
   input wire logic i_sample,
   input wire logic i_mux_en,
   input wire logic [2:0] i_mux_sel,
   input wire logic [7:0] i_dac_code,
   // Channel voltages as codes, channel 0 in the lowest byte
   input wire logic [63:0] i_levels,
   // Comparator
   output logic o_cmp
);
   logic [7:0] held_q = 8'h00;
   // Track while sampling, hold afterwards
   always_ff @(posedge i_clk) begin
      if (i_sample) begin
         held_q <= i_mux_en ? i_levels[{i_mux_sel, 3'b000}+:8] : 8'h00;
      end
   end
   // Level sits half a step above its code, so equal counts as above
   assign o_cmp = held_q >= i_dac_code;
endmodule
